// *** design/flpol_defs.svh ***
// Constants of the classifier action resolver and flow policer.
// Assumes a single core clock; included by the package only.
//
// Functional notes
// RULE1: Class override selects queue, color, drop profile; the code selects only res_queue_class
// RULE2: Egress class override stored with queued packet
// RULE3: Software keeps both classes equal for management port
// RULE4: Egress override class drives PCP/DEI remarking
// RULE5: Per-flow bits suppress service/customer PCP, DEI remark
// RULE6: DEI suppress ignored when port CFI remark set
// RULE7: Loopback bit allows return to source port
// RULE8: CPU-bound packets carry rule reason code
// RULE9: Three bits skip tree, auth, membership filtering
// RULE10: Bit selects default random-early-drop profile
// RULE11: Force-color bit feeds configured policer input color
// RULE12: Skip bit cancels address-limit-only drop
// RULE13: Highest matched slice meters; only its counter counts
// RULE14: Metered slice picks action set by meter result
// RULE15: Unmetered matched slices use in-profile action set
// RULE16: Policer modes: two RFC trTCM, MEF, pass
// RULE17: Rule index selects one of 128 policers
// RULE18: Green within low, yellow within high, red above
// RULE19: Green and yellow counted in 32-bit counters
// RULE20: Red packets dropped and counted separately
// RULE21: Green/yellow may remark DSCP, pick harsher profile
// RULE22: PPPoE DSCP markdown off until global bit set
// RULE23: In-profile set inside profile, out-profile set outside
// RULE24: Override flag queues at egress, not management port
`ifndef FLPOL_DEFS_SVH
`define FLPOL_DEFS_SVH
`define FLPOL_RULES      128
`define FLPOL_SLICES     4
// Register map: addr[9:7] region, addr[6:0] rule or global index
`define FLPOL_RGN_ACT0   3'h0
`define FLPOL_RGN_ACT1   3'h1
`define FLPOL_RGN_CFG    3'h2
`define FLPOL_RGN_BURST  3'h3
`define FLPOL_RGN_BYTES  3'h4
`define FLPOL_RGN_BUCKET 3'h5
`define FLPOL_RGN_GLOBAL 3'h7
`define FLPOL_G_CTRL     7'h00
`define FLPOL_G_GREEN    7'h01
`define FLPOL_G_YELLOW   7'h02
`define FLPOL_G_RED      7'h03
`define FLPOL_CTRL_RESET 1'h0
// Action word 0 fields
`define FLPOL_A0_TC_OVR   0
`define FLPOL_A0_TC       3:1
`define FLPOL_A0_ETC_OVR  4
`define FLPOL_A0_ETC      7:5
`define FLPOL_A0_SPCP_OFF 8
`define FLPOL_A0_CPCP_OFF 9
`define FLPOL_A0_DEI_OFF  10
`define FLPOL_A0_LOOP     11
`define FLPOL_A0_REASON   17:12
`define FLPOL_A0_TREE     18
`define FLPOL_A0_AUTH     19
`define FLPOL_A0_MEMBER   20
`define FLPOL_A0_REDDEF   21
`define FLPOL_A0_FORCE    22
`define FLPOL_A0_COLOR    24:23
`define FLPOL_A0_ADDRCAP  25
// Action word 1: meter-dependent in/out profile sets
`define FLPOL_A1_IN_CHG   0
`define FLPOL_A1_IN_DSCP  6:1
`define FLPOL_A1_OUT_CHG  7
`define FLPOL_A1_OUT_DSCP 13:8
`define FLPOL_A1_IN_CPU   14
`define FLPOL_A1_OUT_CPU  15
`define FLPOL_A1_OUT_AGGR 16
// Meter config and burst words
`define FLPOL_CFG_MODE   1:0
`define FLPOL_CFG_CIR    15:8
`define FLPOL_CFG_PIR    23:16
`define FLPOL_BST_CBS    15:0
`define FLPOL_BST_PBS    31:16
`endif

// *** design/flpol_pkg.sv ***
// Types of the classifier action resolver and flow policer.
// Assumes the constants header is on the include path.
package flpol_pkg;
`include "flpol_defs.svh"

  typedef enum logic [1:0] {FLPOL_GREEN, FLPOL_YELLOW, FLPOL_RED} flpol_color_e;
  typedef enum logic [1:0] {FLPOL_PASS, FLPOL_TR2698, FLPOL_TR4115, FLPOL_MEF} flpol_mode_e;

  typedef struct packed {
    logic               res_valid;
    flpol_color_e       res_color;
    logic               res_drop;
    logic [2:0]         res_queue_class;
    logic               res_class_override;
    logic [2:0]         res_stored_class;
    logic               res_pcp_from_stored;
    logic               res_spcp_remark;
    logic               res_cpcp_remark;
    logic               res_dei_remark;
    logic               res_loop_allow;
    logic               res_cpu;
    logic [5:0]         res_reason;
    logic               res_tree_skip;
    logic               res_auth_skip;
    logic               res_member_skip;
    logic               res_red_default;
    logic               res_red_aggr;
    logic               res_addr_drop;
    logic [1:0]         res_meter_slice;
    logic [3:0]         res_dscp_chg;
    logic [3:0][5:0]    res_dscp;
    logic [31:0]        cnt_green;
    logic [31:0]        cnt_yellow;
    logic [31:0]        cnt_red;
    logic               pppoe_en;
    logic [31:0]        rd_data;
    logic [6:0]         fill_ptr;
    logic               init_done;
  } flpol_state_s;
endpackage : flpol_pkg

// *** design/flpol_policer.sv ***
// Classifier action resolver with 128 two-rate flow policers.
// Assumes matched slices and rule indices from the lookup stage on the
// core clock, and software on the plain register port.
`timescale 1ns/1ps
module flpol_policer
  import flpol_pkg::*;
#(
  parameter int RULES = `FLPOL_RULES
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [9:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  output logic                    pkt_ready,
  input  wire logic               pkt_valid,
  input  wire logic [3:0]         pkt_match,
  input  wire logic [3:0][6:0]    pkt_rule,
  input  wire logic [13:0]        pkt_len,
  input  wire logic [2:0]         pkt_class,
  input  wire logic [1:0]         pkt_color,
  input  wire logic               pkt_pppoe,
  input  wire logic               pkt_addr_cap_drop,
  input  wire logic               port_pcp_remark_en,
  input  wire logic               port_cfi_remark_en,
  output logic                    res_valid,
  output flpol_color_e            res_color,
  output logic                    res_drop,
  output logic      [2:0]         res_queue_class,
  output logic                    res_class_override,
  output logic      [2:0]         res_stored_class,
  output logic                    res_pcp_from_stored,
  output logic                    res_spcp_remark,
  output logic                    res_cpcp_remark,
  output logic                    res_dei_remark,
  output logic                    res_loop_allow,
  output logic                    res_cpu,
  output logic      [5:0]         res_reason,
  output logic                    res_tree_skip,
  output logic                    res_auth_skip,
  output logic                    res_member_skip,
  output logic                    res_red_default,
  output logic                    res_red_aggr,
  output logic                    res_addr_drop,
  output logic      [1:0]         res_meter_slice,
  output logic      [3:0]         res_dscp_chg,
  output logic      [3:0][5:0]    res_dscp
);

  function automatic logic [2:0] top_slice(input logic [3:0] m);
    top_slice = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        top_slice = {1'b1, 2'(i)};
      end
    end
  endfunction : top_slice

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction : sat_sub

  flpol_state_s s;
  flpol_state_s next_s;

  // Plain arrays keep the per-rule tables out of the state struct
  logic [31:0] act0_mem   [RULES];
  logic [31:0] act1_mem   [RULES];
  logic [31:0] cfg_mem    [RULES];
  logic [31:0] burst_mem  [RULES];
  logic [31:0] bytes_mem  [RULES];
  logic [15:0] cb_mem     [RULES];
  logic [15:0] pb_mem     [RULES];

  logic [2:0]   sel_raw;
  logic         hit;
  logic         take;
  logic [1:0]   sel;
  logic [6:0]   rule;
  logic [31:0]  a0;
  logic [31:0]  a1;
  logic [31:0]  cfg;
  logic [15:0]  len16;
  logic [15:0]  cb_base;
  logic [15:0]  pb_base;
  flpol_color_e in_color;
  flpol_color_e color;
  logic         c_dec;
  logic         p_dec;
  logic         out_set;
  logic [2:0]   region;
  logic [6:0]   idx;
  logic [16:0]  cb_sum;
  logic [16:0]  pb_sum;
  logic [16:0]  spill;
  logic [15:0]  cb_fill;
  logic [15:0]  pb_fill;
  logic [3:0]   sl_chg;
  logic [3:0][5:0] sl_dscp;

  assign region  = reg_addr[9:7];
  assign idx     = reg_addr[6:0];
  assign sel_raw = top_slice(pkt_match);
  assign hit     = sel_raw[2];
  assign sel     = sel_raw[1:0];
  assign take    = pkt_valid && s.init_done;
  assign rule    = pkt_rule[sel];                                         // RULE17
  assign a0      = act0_mem[rule];
  assign a1      = act1_mem[rule];
  assign cfg     = cfg_mem[rule];
  assign len16   = {2'b00, pkt_len};

  // Background refill: one policer per cycle, bursts cap the buckets
  always_comb begin
    cb_sum  = {1'b0, cb_mem[s.fill_ptr]} + {9'h000, cfg_mem[s.fill_ptr][`FLPOL_CFG_CIR]};
    spill   = 17'h00000;
    cb_fill = cb_sum[15:0];
    if (cb_sum > {1'b0, burst_mem[s.fill_ptr][`FLPOL_BST_CBS]}) begin
      cb_fill = burst_mem[s.fill_ptr][`FLPOL_BST_CBS];
      spill   = cb_sum - {1'b0, burst_mem[s.fill_ptr][`FLPOL_BST_CBS]};
    end
    // The MEF meter couples committed overflow into the excess bucket
    if (flpol_mode_e'(cfg_mem[s.fill_ptr][`FLPOL_CFG_MODE]) != FLPOL_MEF) begin
      spill = 17'h00000;
    end
    pb_sum  = {1'b0, pb_mem[s.fill_ptr]} + {9'h000, cfg_mem[s.fill_ptr][`FLPOL_CFG_PIR]}
              + spill;
    pb_fill = (pb_sum > {1'b0, burst_mem[s.fill_ptr][`FLPOL_BST_PBS]})
              ? burst_mem[s.fill_ptr][`FLPOL_BST_PBS] : pb_sum[15:0];
  end

  // Meter decision for the selected slice only
  always_comb begin
    cb_base  = cb_mem[rule];
    pb_base  = pb_mem[rule];
    in_color = a0[`FLPOL_A0_FORCE] ? flpol_color_e'(a0[`FLPOL_A0_COLOR])  // RULE11
                                   : flpol_color_e'(pkt_color);
    color    = FLPOL_GREEN;
    c_dec    = 1'b0;
    p_dec    = 1'b0;
    if (hit) begin
      case (flpol_mode_e'(cfg[`FLPOL_CFG_MODE]))                         // RULE16
        FLPOL_TR2698: begin
          if (in_color == FLPOL_RED || pb_base < len16) begin             // RULE18
            color = FLPOL_RED;
          end else if (in_color == FLPOL_YELLOW || cb_base < len16) begin
            color = FLPOL_YELLOW;
            p_dec = 1'b1;
          end else begin
            c_dec = 1'b1;
            p_dec = 1'b1;
          end
        end
        FLPOL_TR4115, FLPOL_MEF: begin
          if (in_color == FLPOL_GREEN && cb_base >= len16) begin           // RULE18
            c_dec = 1'b1;
          end else if (in_color != FLPOL_RED && pb_base >= len16) begin
            color = FLPOL_YELLOW;
            p_dec = 1'b1;
          end else begin
            color = FLPOL_RED;
          end
        end
        default: color = FLPOL_GREEN;
      endcase
    end
    out_set = (color != FLPOL_GREEN);                                     // RULE23
  end

  // Meter-dependent DSCP per matched slice
  for (genvar g = 0; g < `FLPOL_SLICES; g++) begin : g_slice
    logic [31:0] w1;
    logic        use_out;
    assign w1      = act1_mem[pkt_rule[g]];
    assign use_out = hit && (sel == 2'(g)) && out_set;                    // RULE14 RULE15
    assign sl_chg[g]  = pkt_match[g] && (pkt_pppoe ? s.pppoe_en : 1'b1)   // RULE22
                        && (use_out ? w1[`FLPOL_A1_OUT_CHG] : w1[`FLPOL_A1_IN_CHG]);
    assign sl_dscp[g] = use_out ? w1[`FLPOL_A1_OUT_DSCP] : w1[`FLPOL_A1_IN_DSCP]; // RULE21
  end

  always_comb begin
    next_s           = s;
    next_s.res_valid = 1'b0;
    next_s.fill_ptr  = s.fill_ptr + 7'h01;
    if (!s.init_done && s.fill_ptr == 7'h7f) begin
      next_s.init_done = 1'b1;
    end
    if (take) begin
      next_s.res_valid           = 1'b1;
      next_s.res_color           = color;
      next_s.res_drop            = hit && color == FLPOL_RED;             // RULE20
      next_s.res_class_override  = hit && a0[`FLPOL_A0_TC_OVR];           // RULE24
      next_s.res_queue_class     = next_s.res_class_override              // RULE1
                                   ? a0[`FLPOL_A0_TC] : pkt_class;
      next_s.res_pcp_from_stored = hit && a0[`FLPOL_A0_ETC_OVR];          // RULE4
      next_s.res_stored_class    = next_s.res_pcp_from_stored             // RULE2
                                   ? a0[`FLPOL_A0_ETC] : next_s.res_queue_class;
      next_s.res_spcp_remark     = port_pcp_remark_en                     // RULE5
                                   && !(hit && a0[`FLPOL_A0_SPCP_OFF]);
      next_s.res_cpcp_remark     = port_pcp_remark_en && !(hit && a0[`FLPOL_A0_CPCP_OFF]);
      // Legacy CFI remark keeps priority over the per-flow bit
      next_s.res_dei_remark      = port_cfi_remark_en                     // RULE6
                                   || (port_pcp_remark_en && !(hit && a0[`FLPOL_A0_DEI_OFF]));
      next_s.res_loop_allow      = hit && a0[`FLPOL_A0_LOOP];             // RULE7
      next_s.res_cpu             = hit && (out_set ? a1[`FLPOL_A1_OUT_CPU]
                                                   : a1[`FLPOL_A1_IN_CPU]);
      next_s.res_reason          = next_s.res_cpu ? a0[`FLPOL_A0_REASON] : 6'h00; // RULE8
      next_s.res_tree_skip       = hit && a0[`FLPOL_A0_TREE];             // RULE9
      next_s.res_auth_skip       = hit && a0[`FLPOL_A0_AUTH];             // RULE9
      next_s.res_member_skip     = hit && a0[`FLPOL_A0_MEMBER];           // RULE9
      next_s.res_red_default     = hit && a0[`FLPOL_A0_REDDEF];           // RULE10
      next_s.res_red_aggr        = hit && color == FLPOL_YELLOW           // RULE21
                                   && a1[`FLPOL_A1_OUT_AGGR];
      next_s.res_addr_drop       = pkt_addr_cap_drop                      // RULE12
                                   && !(hit && a0[`FLPOL_A0_ADDRCAP]);
      next_s.res_meter_slice     = sel;                                   // RULE13
      next_s.res_dscp_chg        = sl_chg;
      next_s.res_dscp            = sl_dscp;
    end
    // Software clears apply first; a packet in the same cycle is counted on top
    if (reg_wr && region == `FLPOL_RGN_GLOBAL) begin
      case (idx)
        `FLPOL_G_CTRL:   next_s.pppoe_en   = reg_wdata[0];
        `FLPOL_G_GREEN:  next_s.cnt_green  = 32'h00000000;
        `FLPOL_G_YELLOW: next_s.cnt_yellow = 32'h00000000;
        `FLPOL_G_RED:    next_s.cnt_red    = 32'h00000000;
        default:         next_s.pppoe_en   = s.pppoe_en;
      endcase
    end
    if (take && hit) begin
      case (color)
        FLPOL_GREEN:  next_s.cnt_green  = next_s.cnt_green + 32'h00000001;  // RULE19
        FLPOL_YELLOW: next_s.cnt_yellow = next_s.cnt_yellow + 32'h00000001; // RULE19
        default:      next_s.cnt_red    = next_s.cnt_red + 32'h00000001;    // RULE20
      endcase
    end
    if (reg_rd) begin
      case (region)
        `FLPOL_RGN_ACT0:   next_s.rd_data = act0_mem[idx];
        `FLPOL_RGN_ACT1:   next_s.rd_data = act1_mem[idx];
        `FLPOL_RGN_CFG:    next_s.rd_data = cfg_mem[idx];
        `FLPOL_RGN_BURST:  next_s.rd_data = burst_mem[idx];
        `FLPOL_RGN_BYTES:  next_s.rd_data = bytes_mem[idx];
        `FLPOL_RGN_BUCKET: next_s.rd_data = {pb_mem[idx], cb_mem[idx]};
        `FLPOL_RGN_GLOBAL: begin
          case (idx)
            `FLPOL_G_CTRL:   next_s.rd_data = {31'h00000000, s.pppoe_en};
            `FLPOL_G_GREEN:  next_s.rd_data = s.cnt_green;
            `FLPOL_G_YELLOW: next_s.rd_data = s.cnt_yellow;
            `FLPOL_G_RED:    next_s.rd_data = s.cnt_red;
            default:         next_s.rd_data = 32'h00000000;
          endcase
        end
        default: next_s.rd_data = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
      s.pppoe_en <= `FLPOL_CTRL_RESET;                                    // RULE22
    end else begin
      s <= next_s;
    end
  end

  // Tables are cleared by a 128-cycle sweep after each reset
  always_ff @(posedge clock) begin
    if (!s.init_done) begin
      act0_mem[s.fill_ptr]  <= 32'h00000000;
      act1_mem[s.fill_ptr]  <= 32'h00000000;
      cfg_mem[s.fill_ptr]   <= 32'h00000000;
      burst_mem[s.fill_ptr] <= 32'h00000000;
      bytes_mem[s.fill_ptr] <= 32'h00000000;
      cb_mem[s.fill_ptr]    <= 16'h0000;
      pb_mem[s.fill_ptr]    <= 16'h0000;
    end else begin
      if (reg_wr) begin
        case (region)
          `FLPOL_RGN_ACT0:  act0_mem[idx]  <= reg_wdata;
          `FLPOL_RGN_ACT1:  act1_mem[idx]  <= reg_wdata;
          `FLPOL_RGN_CFG:   cfg_mem[idx]   <= reg_wdata;
          `FLPOL_RGN_BURST: burst_mem[idx] <= reg_wdata;
          `FLPOL_RGN_BYTES: bytes_mem[idx] <= 32'h00000000;
          default:          act0_mem[idx]  <= act0_mem[idx];
        endcase
      end
      cb_mem[s.fill_ptr] <= cb_fill;
      pb_mem[s.fill_ptr] <= pb_fill;
      if (take && hit) begin
        // Only the selected meter and its byte counter are touched
        cb_mem[rule] <= sat_sub((rule == s.fill_ptr) ? cb_fill : cb_base,  // RULE13
                                c_dec ? len16 : 16'h0000);
        pb_mem[rule] <= sat_sub((rule == s.fill_ptr) ? pb_fill : pb_base,
                                p_dec ? len16 : 16'h0000);
        bytes_mem[rule] <= ((reg_wr && region == `FLPOL_RGN_BYTES && idx == rule)
                            ? 32'h00000000 : bytes_mem[rule]) + {18'h00000, pkt_len};
      end
    end
  end

  assign reg_rdata           = s.rd_data;
  assign pkt_ready           = s.init_done;
  assign res_valid           = s.res_valid;
  assign res_color           = s.res_color;
  assign res_drop            = s.res_drop;
  assign res_queue_class     = s.res_queue_class;
  assign res_class_override  = s.res_class_override;
  assign res_stored_class    = s.res_stored_class;
  assign res_pcp_from_stored = s.res_pcp_from_stored;
  assign res_spcp_remark     = s.res_spcp_remark;
  assign res_cpcp_remark     = s.res_cpcp_remark;
  assign res_dei_remark      = s.res_dei_remark;
  assign res_loop_allow      = s.res_loop_allow;
  assign res_cpu             = s.res_cpu;
  assign res_reason          = s.res_reason;
  assign res_tree_skip       = s.res_tree_skip;
  assign res_auth_skip       = s.res_auth_skip;
  assign res_member_skip     = s.res_member_skip;
  assign res_red_default     = s.res_red_default;
  assign res_red_aggr        = s.res_red_aggr;
  assign res_addr_drop       = s.res_addr_drop;
  assign res_meter_slice     = s.res_meter_slice;
  assign res_dscp_chg        = s.res_dscp_chg;
  assign res_dscp            = s.res_dscp;

  default clocking cb_clk @(posedge clock); endclocking
  default disable iff (!rst_n);

  red_drop_a: assert property (res_valid && res_color == FLPOL_RED |-> res_drop) // RULE20
    else $error("red packet not dropped");
  green_count_a: assert property (take && hit && color == FLPOL_GREEN          // RULE19
      && !(reg_wr && region == `FLPOL_RGN_GLOBAL && idx == `FLPOL_G_GREEN)
      |=> s.cnt_green == $past(s.cnt_green) + 32'h00000001)
    else $error("green counter missed a packet");
  pass_green_a: assert property (take && !hit |=> res_color == FLPOL_GREEN && !res_drop) // RULE16
    else $error("unmatched packet not passed green");
  class_ovr_a: assert property (take && hit && a0[`FLPOL_A0_TC_OVR]            // RULE1
      |=> res_queue_class == $past(a0[`FLPOL_A0_TC]) && res_class_override)
    else $error("replacement class not applied");
  dei_compat_a: assert property (take && port_cfi_remark_en |=> res_dei_remark) // RULE6
    else $error("cfi remark enable overridden");
  addr_skip_a: assert property (take && hit && a0[`FLPOL_A0_ADDRCAP] |=> !res_addr_drop) // RULE12
    else $error("address-limit drop not cancelled");
  pppoe_block_a: assert property (take && pkt_pppoe && !s.pppoe_en |=> res_dscp_chg == 4'h0) // RULE22
    else $error("pppoe dscp markdown while disabled");
  meter_slice_a: assert property (take && pkt_match == 4'hf |=> res_meter_slice == 2'h3) // RULE13
    else $error("wrong slice metered");
  egress_cls_a: assert property (take && hit && a0[`FLPOL_A0_ETC_OVR]          // RULE2
      |=> res_stored_class == $past(a0[`FLPOL_A0_ETC]) && res_pcp_from_stored)
    else $error("egress class not stored");
  red_seen_c: cover property (take && hit |=> res_drop);
  yellow_seen_c: cover property (take && hit |=> res_color == FLPOL_YELLOW);
  multi_slice_c: cover property (take && pkt_match[0] && pkt_match[2]);
  pppoe_on_c: cover property (take && pkt_pppoe && s.pppoe_en && hit);

endmodule : flpol_policer

// *** tb/flpol_feed.sv ***
// Lookup-stage model feeding match results into the policer.
// Assumes the bench raises send for one cycle per packet.
`timescale 1ns/1ps
module flpol_feed (
  input  wire logic               clock,
  input  wire logic               send,
  input  wire logic [3:0]         s_m,
  input  wire logic [27:0]        s_r,
  input  wire logic [13:0]        s_len,
  output logic                    pkt_valid,
  output logic      [3:0]         pkt_match,
  output logic      [3:0][6:0]    pkt_rule,
  output logic      [13:0]        pkt_len
);
  initial begin
    pkt_valid = 1'h0;
    pkt_match = 4'h0;
    pkt_rule  = '0;
    pkt_len   = 14'h0;
  end
  // Idle fields toggle so a stale capture cannot pass
  always @(posedge clock) begin
    pkt_valid <= send;
    pkt_match <= send ? s_m : ~pkt_match;
    pkt_rule  <= send ? s_r : ~pkt_rule;
    pkt_len   <= send ? s_len : ~pkt_len;
  end
endmodule : flpol_feed

// *** tb/tb.sv ***
// Self-checking bench for the action resolver and flow policer.
// Assumes the feed model in front of the packet port.
`timescale 1ns/1ps
module tb;
  import flpol_pkg::*;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, send = 0, pkt_pppoe = 0;
  logic pkt_addr_cap_drop = 0, port_pcp_remark_en = 0, port_cfi_remark_en = 0;
  logic [9:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [3:0] s_m = 0, pkt_match, res_dscp_chg;
  logic [27:0] s_r = 0;
  logic [13:0] s_len = 14'h40, pkt_len;
  logic [2:0] pkt_class = 0, res_queue_class, res_stored_class;
  logic [1:0] pkt_color = 0, res_meter_slice;
  logic [3:0][6:0] pkt_rule;
  logic [3:0][5:0] res_dscp;
  logic [5:0] res_reason;
  flpol_color_e res_color;
  logic pkt_ready, pkt_valid, res_valid, res_drop, res_class_override, res_pcp_from_stored;
  logic res_spcp_remark, res_cpcp_remark, res_dei_remark, res_loop_allow, res_cpu;
  logic res_tree_skip, res_auth_skip, res_member_skip, res_red_default, res_red_aggr;
  logic res_addr_drop;
  int n_fail = 0, checks = 0, cyc = 0;

  flpol_policer flpol_policer_i (.*);
  flpol_feed flpol_feed_i (.*);

  initial forever #4 clock = ~clock;

  task end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim;
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr

  task rdc(input logic [9:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 chk("rdata", reg_rdata, exp);
  endtask : rdc

  task pkt(input logic [3:0] m, input logic [27:0] r, input logic v);
    @(posedge clock);
    send <= 1'h1;
    s_m <= m;
    s_r <= r;
    @(posedge clock);
    send <= 1'h0;
    @(posedge clock);
    #1 chk("valid", res_valid, v);
  endtask : pkt

  task t_reset;
    pkt(4'h1, 28'h5, 1'h0);
    rdc(10'h380, 32'h0);
    rdc(10'h300, 32'h0);
    wr(10'h380, 32'h1);
    rdc(10'h380, 32'h1);
    repeat (200) if (!pkt_ready) @(posedge clock);
    chk("ready", pkt_ready, 1'h1);
  endtask : t_reset

  // Pass-through meter, meter-independent actions at once except customer PCP suppress, auth skip and red default, left clear
  task t_actions;
    wr(10'h005, 32'h0216dd7b);
    wr(10'h085, 32'h0000402b);
    port_pcp_remark_en <= 1'h1;
    port_cfi_remark_en <= 1'h1;
    pkt_addr_cap_drop <= 1'h1;
    pkt_pppoe <= 1'h1;
    pkt(4'h1, 28'h5, 1'h1);
    chk("acts", {res_queue_class, res_class_override, res_stored_class, res_pcp_from_stored,
      res_spcp_remark, res_cpcp_remark, res_dei_remark, res_loop_allow, res_cpu,
      res_tree_skip, res_auth_skip, res_member_skip, res_red_default, res_addr_drop,
      res_drop}, 32'h5bbe8);
    chk("reason", res_reason, 32'h2d);
    chk("color", res_color, FLPOL_GREEN);
    chk("dscp0", {res_dscp_chg[0], res_dscp[0]}, 32'h55);
    rdc(10'h381, 32'h1);
    rdc(10'h205, 32'h40);
    // No slice matched: pass green, address-limit drop stands
    pkt(4'h0, 28'h5, 1'h1);
    chk("nohit", {res_color, res_drop, res_addr_drop, res_class_override}, {FLPOL_GREEN, 3'h2});
    wr(10'h380, 32'h0);
    pkt(4'h1, 28'h5, 1'h1);
    chk("pppoe", res_dscp_chg, 32'h0);
    pkt_pppoe <= 1'h0;
  endtask : t_actions

  // Two slices: upper one metered red, lower keeps its in-profile set
  task t_multi;
    wr(10'h107, 32'h1);
    wr(10'h087, 32'h2a80);
    wr(10'h089, 32'h23);
    pkt(4'h5, 28'h1c009, 1'h1);
    chk("slice", res_meter_slice, 32'h2);
    chk("red", {res_color, res_drop}, {FLPOL_RED, 1'h1});
    chk("chg", res_dscp_chg, 32'h5);
    chk("dscp", {res_dscp[2], res_dscp[0]}, 32'ha91);
    rdc(10'h383, 32'h1);
    rdc(10'h209, 32'h0);
    rdc(10'h207, 32'h40);
  endtask : t_multi

  // Peak bucket only: committed rate exceeded, peak not
  task t_yellow;
    wr(10'h103, 32'h00ff0001);
    wr(10'h183, 32'hffff0000);
    wr(10'h083, 32'h10000);
    repeat (300) @(posedge clock);
    pkt(4'h8, 28'h600000, 1'h1);
    chk("yel", {res_color, res_drop, res_red_aggr}, {FLPOL_YELLOW, 2'h1});
    chk("slice", res_meter_slice, 32'h3);
    rdc(10'h382, 32'h1);
    // Force-color bit sets a red input color; all four slices match, slice 3 meters
    wr(10'h003, 32'h01400000);
    pkt(4'hf, 28'h600000, 1'h1);
    chk("forced", {res_color, res_drop, res_meter_slice}, {FLPOL_RED, 3'h7});
    rdc(10'h383, 32'h2);
  endtask : t_yellow

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    t_reset;
    t_actions;
    t_multi;
    t_yellow;
    end_sim;
  end
endmodule : tb
